/* File: inc/swisc_pkg.sv */
// package: constants and carriers for the switch id and start control block
package swisc_pkg;
  localparam logic [7:0] ADDR_FAMILY = 8'h00;
  localparam logic [7:0] ADDR_REV_START = 8'h01;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h88;
  localparam logic [7:0] ADDR_PORT_INT_LO = 8'h7c;
  localparam logic [7:0] ADDR_PORT_INT_HI = 8'h7d;
  localparam logic [7:0] ADDR_P1_LO = 8'h20;
  localparam logic [7:0] ADDR_P1_HI = 8'h24;
  localparam logic [7:0] ADDR_P2_LO = 8'h30;
  localparam logic [7:0] ADDR_P2_HI = 8'h34;
  localparam logic [7:0] ADDR_CHIP_ID_EXT = 8'hfe;
  localparam int START_BIT = 0;
  localparam int CHIP_CODE_LSB = 4;
  localparam int CHIP_ID_EXT_BIT = 7;
  localparam logic [7:0] START_RESET = 8'h00;
  localparam logic [3:0] EE_UPPER_REQUIRED = 4'h0;
  // strap combinations {config_strap_high, config_strap_low}
  localparam logic [1:0] STRAP_EEPROM = 2'b00;
  localparam logic [1:0] STRAP_SERIAL = 2'b10;
  localparam logic [1:0] STRAP_ALT = 2'b01;
  localparam logic [1:0] STRAP_FACTORY = 2'b11;

  typedef enum logic [3:0] {
    SWISC_GRP_NONE = 4'h0,
    SWISC_GRP_CHIP_ID = 4'h1,
    SWISC_GRP_PORT1 = 4'h2,
    SWISC_GRP_PORT2 = 4'h3,
    SWISC_GRP_PORT_INT = 4'h4,
    SWISC_GRP_SELF_TEST = 4'h5
  } swisc_grp_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } swisc_req_t;

  typedef struct packed {
    logic req;
    logic [7:0] addr;
  } swisc_ee_req_t;

  typedef struct packed {
    logic done;
    logic absent;
    logic [7:0] data;
  } swisc_ee_rsp_t;

  typedef enum logic [5:0] {
    SWISC_ST_STRAP = 6'b000001,
    SWISC_ST_EE_B0 = 6'b000010,
    SWISC_ST_EE_B1 = 6'b000100,
    SWISC_ST_EE_COPY = 6'b001000,
    SWISC_ST_WAIT_SW = 6'b010000,
    SWISC_ST_RUN = 6'b100000
  } swisc_state_t;
endpackage

/* File: src/swisc_strap_sync.sv */
// two-stage synchroniser with one-shot capture of the strap pins
`timescale 1ns/1ps
module swisc_strap_sync (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic [1:0] strap_pin, // raw strap pins {high, low}
  output logic [1:0] strap_mode, // captured mode
  output logic strap_valid // mode has been captured
);
  import swisc_pkg::*;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] mode;
    logic [1:0] cnt;
  } swisc_sync_t;

  swisc_sync_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.meta = strap_pin;
    next_st.sync = st.meta;
    // capture once the sync chain holds post-reset samples, then freeze
    // sync only carries a real pin sample from the second edge on, so capture waits for the third
    if (st.cnt != 2'd3) begin
      next_st.cnt = st.cnt + 2'd1;
      if (st.cnt == 2'd2) begin
        next_st.mode = st.sync;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign strap_mode = st.mode;
  assign strap_valid = (st.cnt == 2'd3);
endmodule

/* File: src/swisc_top.sv */
// switch identification, start control and register group decode
// How it works
// - with straps at serial-slave (1,0) switching starts only after software writes one to the start bit.
// - with both straps low the block reads the eeprom after reset and then starts on its own.
// - if no eeprom answers, the built-in defaults stay and switching starts with them.
// - eeprom contents count only if byte 0 is the family code and byte 1 bits 7:4 are zero.
// - a good eeprom is copied into the registers before switching starts.
// - with straps (1,0) or (0,1) the block stays stopped until software sets the start bit.
// - the start bit resets to zero and writing zero to it halts switching.
// - register 1 bits 7:4 are a read-only chip code, the rest of the id is bit 7 of register 254.
// - port 1 control sits at 0x20-0x24 and port 2 control at 0x30-0x34.
// - self-test control sits at 0x88 and the port interrupt registers at 0x7c-0x7d.
`timescale 1ns/1ps
module swisc_top #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary identification value
  parameter logic [3:0] CHIP_CODE = 4'h3, // arbitrary identification value
  parameter logic [2:0] REVISION = 3'h5, // arbitrary identification value
  parameter int EE_BYTES = 256 // eeprom size in bytes; bytes 2 up to this count minus one are copied from a valid eeprom
) (
  input wire logic clk, // system clock, 125 MHz
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic config_strap_high, // strap pin, asynchronous
  input wire logic config_strap_low, // strap pin, asynchronous
  input wire logic chip_id_ext, // chip id bit mirrored into register 254 bit 7
  input wire swisc_pkg::swisc_req_t reg_req, // register access from serial transport
  output logic [7:0] reg_rdata, // read data for own registers
  output swisc_pkg::swisc_grp_t reg_grp, // group hit by the current address
  output logic [2:0] reg_grp_offset, // offset within port group
  output swisc_pkg::swisc_ee_req_t ee_req, // byte request to eeprom reader
  input wire swisc_pkg::swisc_ee_rsp_t ee_rsp, // eeprom reader answer
  output logic load_we, // write strobe of an eeprom byte into the register file
  output logic [7:0] load_addr, // register address being loaded
  output logic [7:0] load_data, // byte being loaded
  output logic switch_run, // switching enabled
  output logic [1:0] strap_mode, // captured strap mode
  output logic factory_mode // straps at reserved factory setting
);
  import swisc_pkg::*;

  typedef struct packed {
    swisc_state_t fsm;
    logic start;
    logic [8:0] idx;
    logic ee_req;
    logic [7:0] rdata;
    logic ld_we;
    logic [7:0] ld_addr;
    logic [7:0] ld_data;
  } swisc_top_st_t;

  swisc_top_st_t st, next_st;
  logic strap_valid;

  function automatic swisc_grp_t decode_grp(input logic [7:0] a);
    if (a == ADDR_FAMILY || a == ADDR_REV_START) begin
      decode_grp = SWISC_GRP_CHIP_ID;
    end else if (a >= ADDR_P1_LO && a <= ADDR_P1_HI) begin
      decode_grp = SWISC_GRP_PORT1;
    end else if (a >= ADDR_P2_LO && a <= ADDR_P2_HI) begin
      decode_grp = SWISC_GRP_PORT2;
    end else if (a == ADDR_PORT_INT_LO || a == ADDR_PORT_INT_HI) begin
      decode_grp = SWISC_GRP_PORT_INT;
    end else if (a == ADDR_SELF_TEST) begin
      decode_grp = SWISC_GRP_SELF_TEST;
    end else begin
      decode_grp = SWISC_GRP_NONE;
    end
  endfunction

  // register 1 write: only its start bit takes the data
  function automatic logic is_start_wr(input swisc_req_t r);
    is_start_wr = r.wr && (r.addr == ADDR_REV_START);
  endfunction

  swisc_strap_sync swisc_strap_sync_i (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .strap_pin({config_strap_high, config_strap_low}),
    .strap_mode(strap_mode),
    .strap_valid(strap_valid)
  );

  always_comb begin
    next_st = st;
    next_st.ld_we = 1'b0;
    // read path: chip code and revision are fixed, only the start bit is state
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_FAMILY: next_st.rdata = FAMILY_CODE;
        ADDR_REV_START: next_st.rdata = {CHIP_CODE, REVISION, st.start};
        ADDR_CHIP_ID_EXT: next_st.rdata = {chip_id_ext, 7'h00};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // only bit 0 of register 1 is writable; upper bits ignore writes
    if (is_start_wr(reg_req)) begin
      next_st.start = reg_req.wdata[START_BIT];
    end
    case (st.fsm)
      SWISC_ST_STRAP: begin
        if (strap_valid) begin
          if (strap_mode == STRAP_EEPROM) begin
            next_st.fsm = SWISC_ST_EE_B0;
            next_st.idx = 9'd0;
            next_st.ee_req = 1'b1;
          end else begin
            next_st.fsm = SWISC_ST_WAIT_SW;
          end
        end
      end
      SWISC_ST_EE_B0: begin
        if (ee_rsp.done) begin
          next_st.ee_req = 1'b0;
          if (ee_rsp.absent || ee_rsp.data != FAMILY_CODE) begin
            next_st.fsm = SWISC_ST_RUN;
            next_st.start = 1'b1;
          end else begin
            next_st.fsm = SWISC_ST_EE_B1;
            next_st.idx = 9'd1;
            next_st.ee_req = 1'b1;
          end
        end
      end
      SWISC_ST_EE_B1: begin
        if (ee_rsp.done) begin
          next_st.ee_req = 1'b0;
          if (ee_rsp.absent || ee_rsp.data[7:CHIP_CODE_LSB] != EE_UPPER_REQUIRED) begin
            next_st.fsm = SWISC_ST_RUN;
            next_st.start = 1'b1;
          end else begin
            // id bytes are read-only, so copying starts at register 2
            next_st.fsm = SWISC_ST_EE_COPY;
            next_st.idx = 9'd2;
            next_st.ee_req = 1'b1;
          end
        end
      end
      SWISC_ST_EE_COPY: begin
        if (st.idx == 9'(EE_BYTES)) begin
          // the last byte was strobed on the previous edge, so it is in place before switching starts
          next_st.fsm = SWISC_ST_RUN;
          next_st.start = 1'b1;
        end else if (ee_rsp.done) begin
          next_st.ee_req = 1'b0;
          if (!ee_rsp.absent) begin
            next_st.ld_we = 1'b1;
            next_st.ld_addr = st.idx[7:0];
            next_st.ld_data = ee_rsp.data;
          end
          if (st.idx == 9'(EE_BYTES - 1) || ee_rsp.absent) begin
            next_st.idx = 9'(EE_BYTES);
          end else begin
            next_st.idx = st.idx + 9'd1;
            next_st.ee_req = 1'b1;
          end
        end
      end
      SWISC_ST_WAIT_SW: begin
        if (st.start) begin
          next_st.fsm = SWISC_ST_RUN;
        end
      end
      SWISC_ST_RUN: begin
        if (!st.start) begin
          next_st.fsm = SWISC_ST_WAIT_SW;
        end
      end
      default: next_st.fsm = SWISC_ST_STRAP;
    endcase
    // a software write in the same cycle as the auto start wins: software has the final word
    if (is_start_wr(reg_req) && st.fsm != SWISC_ST_WAIT_SW && st.fsm != SWISC_ST_RUN) begin
      next_st.start = reg_req.wdata[START_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{fsm: SWISC_ST_STRAP, start: START_RESET[START_BIT], default: '0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_grp = decode_grp(reg_req.addr);
  assign reg_grp_offset = reg_req.addr[2:0];
  assign ee_req = '{req: st.ee_req, addr: st.idx[7:0]};
  assign load_we = st.ld_we;
  assign load_addr = st.ld_addr;
  assign load_data = st.ld_data;
  assign switch_run = (st.fsm == SWISC_ST_RUN) && st.start;
  assign factory_mode = strap_valid && (strap_mode == STRAP_FACTORY);
endmodule

/* File: verification/swisc_eeprom_model.sv */
// eeprom reader stand-in: answers each byte request after a short delay
`timescale 1ns/1ps
module swisc_eeprom_model #(
  parameter logic [7:0] FAMILY = 8'h5a // must match the design's family code
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire swisc_pkg::swisc_ee_req_t ee_req, // byte request
  output swisc_pkg::swisc_ee_rsp_t ee_rsp, // answer
  input wire logic absent, // no eeprom fitted
  input wire logic bad, // corrupt family byte
  input wire logic bad_hi // nonzero upper nibble in byte 1
);
  import swisc_pkg::*;
  logic [2:0] cnt;
  logic [7:0] b;
  always_comb begin
    b = (ee_req.addr == 8'h00) ? (bad ? ~FAMILY : FAMILY) :
      (ee_req.addr == 8'h01) ? (bad_hi ? 8'h13 : 8'h03) : ee_req.addr * 8'h11;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 3'h0;
      ee_rsp <= '0;
    end else begin
      ee_rsp.done <= 1'b0;
      // data toggles outside done so a stale byte is never mistaken for fresh
      ee_rsp.data <= ~ee_rsp.data;
      if (ee_req.req && !ee_rsp.done) begin
        cnt <= cnt + 3'h1;
        if (cnt == 3'h3) begin
          cnt <= 3'h0;
          ee_rsp <= '{done: 1'b1, absent: absent, data: b};
        end
      end
    end
  end
endmodule

/* File: verification/swisc_assertions.sv */
// checker for the id, start control and decode ports
`timescale 1ns/1ps
module swisc_assertions
  import swisc_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary identification value
  parameter logic [3:0] CHIP_CODE = 4'h3 // arbitrary identification value
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire swisc_pkg::swisc_req_t reg_req, // register access
  input wire logic [7:0] reg_rdata, // read data
  input wire swisc_pkg::swisc_grp_t reg_grp, // decoded group
  input wire logic load_we, // eeprom load strobe
  input wire logic [7:0] load_addr, // eeprom load address
  input wire logic switch_run, // switching enabled
  input wire logic [1:0] strap_mode // captured strap
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr1 = ce && reg_req.wr && reg_req.addr == ADDR_REV_START;
  wire man = strap_mode == STRAP_SERIAL || strap_mode == STRAP_ALT;
  // a start write needs two edges: one for the bit, one for the state, so the write one edge back is excused
  property p_hold_stop;
    man && !switch_run && !(wr1 && reg_req.wdata[0]) && !$past(wr1 && reg_req.wdata[0]) |=> !switch_run;
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("switch started without start write");
  property p_start; man && wr1 && reg_req.wdata[0] |-> ##[1:2] switch_run; endproperty
  a_start: assert property (p_start) else $error("start write did not start switch");
  property p_stop; wr1 && !reg_req.wdata[0] |-> ##[1:2] !switch_run; endproperty
  a_stop: assert property (p_stop) else $error("stop write did not halt switch");
  property p_grp_port; (reg_req.addr inside {[8'h20:8'h24]} |-> reg_grp == SWISC_GRP_PORT1)
    and (reg_req.addr inside {[8'h30:8'h34]} |-> reg_grp == SWISC_GRP_PORT2); endproperty
  a_grp_port: assert property (p_grp_port) else $error("port group decode wrong");
  property p_grp_misc; (reg_req.addr == 8'h88 |-> reg_grp == SWISC_GRP_SELF_TEST)
    and (reg_req.addr inside {8'h7c, 8'h7d} |-> reg_grp == SWISC_GRP_PORT_INT); endproperty
  a_grp_misc: assert property (p_grp_misc) else $error("self-test or interrupt decode wrong");
  property p_family; ce && reg_req.rd && reg_req.addr == ADDR_FAMILY |=> reg_rdata == FAMILY_CODE; endproperty
  a_family: assert property (p_family) else $error("family read wrong");
  property p_chip; ce && reg_req.rd && reg_req.addr == ADDR_REV_START |=> reg_rdata[7:4] == CHIP_CODE; endproperty
  a_chip: assert property (p_chip) else $error("chip code read wrong");
  property p_strap_hold; strap_mode != 2'b00 |=> $stable(strap_mode); endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("captured strap changed");
  property p_load; load_we |-> !switch_run && load_addr >= 8'h02; endproperty
  a_load: assert property (p_load) else $error("load after start or into id bytes");
  cover property (load_we);
  cover property (man && wr1 && reg_req.wdata[0]);
  cover property (wr1 && !reg_req.wdata[0] && switch_run);
endmodule
bind swisc_top swisc_assertions #(.FAMILY_CODE(FAMILY_CODE), .CHIP_CODE(CHIP_CODE)) swisc_assertions_i (
  .clk(clk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_grp(reg_grp),
  .load_we(load_we), .load_addr(load_addr), .switch_run(switch_run), .strap_mode(strap_mode));

/* File: verification/swisc_top_test.sv */
// self-checking bench: decode, manual start, eeprom start
`timescale 1ns/1ps
module swisc_top_test;
  import swisc_pkg::*;
  logic clk = 0, rst = 1, sh = 0, sl = 0, ab = 0, bad = 0, badh = 0, ce = 1, cid = 1;
  swisc_req_t rq = '0;
  logic [7:0] rdata, laddr, ldata;
  logic [2:0] off;
  swisc_grp_t grp;
  swisc_ee_req_t eq;
  swisc_ee_rsp_t ers;
  logic lwe, run, fac;
  logic [1:0] mode;
  int error_cnt = 0, cmp_count = 0, loads = 0;
  // {addr, expected group}
  logic [11:0] rows [14] = '{12'h001, 12'h011, 12'h202, 12'h242, 12'h250, 12'h303, 12'h343, 12'h350,
    12'h7c4, 12'h7d4, 12'h7e0, 12'h885, 12'h890, 12'h1f0};
  swisc_top #(.EE_BYTES(8)) swisc_top_i (.clk(clk), .rst(rst), .ce(ce), .config_strap_high(sh),
    .config_strap_low(sl), .chip_id_ext(cid), .reg_req(rq), .reg_rdata(rdata), .reg_grp(grp),
    .reg_grp_offset(off), .ee_req(eq), .ee_rsp(ers), .load_we(lwe), .load_addr(laddr), .load_data(ldata),
    .switch_run(run), .strap_mode(mode), .factory_mode(fac));
  swisc_eeprom_model swisc_eeprom_model_i (.clk(clk), .rst(rst), .ee_req(eq), .ee_rsp(ers), .absent(ab),
    .bad(bad), .bad_hi(badh));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    rq = '{wr: w, rd: !w, addr: a, wdata: d};
    cyc(1);
    // one idle edge, so back-to-back calls never re-raise a strobe in the same step
    rq = '0;
    cyc(1);
  endtask
  task automatic boot(logic [1:0] s, logic a, logic b, logic h);
    {sh, sl} = s;
    ab = a;
    bad = b;
    badh = h;
    loads = 0;
    rst = 1;
    cyc(20);
    rst = 0;
    cyc(8);
  endtask
  task automatic wait_run;
    int i;
    for (i = 0; i < 300 && run !== 1'b1; i++) cyc(1);
    if (run !== 1'b1) begin
      error_cnt++;
      $display("Error switch_run expected 1 seen %b", run);
      tally_and_finish();
    end
  endtask
  // loads arrive in address order from 2; the stand-in fills each byte with its address times 0x11
  always @(negedge clk) begin
    if (lwe === 1'b1) begin
      chk("load_addr", 8'(loads + 2), laddr);
      chk("load_data", 8'(loads + 2) * 8'h11, ldata);
      loads++;
    end
  end
  initial begin
    @(negedge clk);
    boot(STRAP_SERIAL, 0, 0, 0);
    // straps move after capture; the captured mode must not follow
    {sh, sl} = 2'b01;
    cyc(4);
    chk("strap_mode", 8'(STRAP_SERIAL), 8'(mode));
    for (int k = 0; k < 14; k++) begin
      rq.addr = rows[k][11:4];
      cyc(1);
      chk("reg_grp", {4'h0, rows[k][3:0]}, {4'h0, grp});
      chk("offset", {5'h0, rows[k][6:4]}, {5'h0, off});
    end
    acc(0, ADDR_FAMILY, 8'h00);
    chk("family", 8'h5a, rdata);
    acc(0, 8'h05, 8'h00);
    chk("unmapped", 8'h00, rdata);
    acc(0, ADDR_CHIP_ID_EXT, 8'h00);
    chk("chip_id_ext", 8'h80, rdata);
    cid = 0;
    acc(0, ADDR_CHIP_ID_EXT, 8'h00);
    chk("chip_id_ext", 8'h00, rdata);
    cyc(12500); // host settle time before starting
    chk("run", 8'h00, 8'(run));
    acc(1, ADDR_REV_START, 8'hfe);
    cyc(2);
    chk("run", 8'h00, 8'(run));
    acc(1, ADDR_REV_START, 8'h01);
    cyc(1);
    chk("run", 8'h01, 8'(run));
    acc(0, ADDR_REV_START, 8'h00);
    chk("rev_start", 8'h3b, rdata);
    acc(1, ADDR_REV_START, 8'h00);
    cyc(1);
    chk("run", 8'h00, 8'(run));
    boot(STRAP_ALT, 0, 0, 0);
    cyc(40);
    chk("run", 8'h00, 8'(run));
    // a start write while the clock enable is low must be lost
    ce = 0;
    acc(1, ADDR_REV_START, 8'h01);
    ce = 1;
    cyc(2);
    chk("run", 8'h00, 8'(run));
    acc(1, ADDR_REV_START, 8'h01);
    cyc(1);
    chk("run", 8'h01, 8'(run));
    boot(STRAP_FACTORY, 0, 0, 0);
    chk("factory", 8'h01, 8'(fac));
    chk("run", 8'h00, 8'(run));
    for (int k = 0; k < 4; k++) begin
      boot(STRAP_EEPROM, k == 2, k == 1, k == 3);
      wait_run();
      chk("loads", 8'(k == 0 ? 6 : 0), 8'(loads));
      acc(0, ADDR_REV_START, 8'h00);
      chk("auto_start", 8'h3b, rdata);
    end
    tally_and_finish();
  end
endmodule
